// ---- verilog/sqt_top.sv ----
// sequencer wait slot, crystal settle gating and host reset release timers
// Operation
// - hold direction field picks no stall, up only, down only or both
// - hold source 0 stalls the wait slot until hold release pin is active
// - hold source 1 runs an internal timer and continues when it expires
// - pin wait gives up after 500 ms when limit bit set, else waits forever
// - hold code 0000 with hold source 1 adds nothing beyond the normal slot length
// - hold code 0001..1111 selects 512 us doubling up to about 8.4 s
// - output enable bit drives slow clock on pins, may be paused
// - rtc gate bit withholds rtc clock until settle timer expires
// - pin gate bit withholds pin clock until settle timer expires
// - settle starts at third falling oscillator edge, or crystal bit rise
// - crystal present bit is loaded from backup domain after core reset
// - settle code 000 disables delay, else 0.52 s steps up to 3.6 s
// - trigger field selects wake, system up, power up or reset exit
// - reset hold code zero releases host reset right after the trigger
// - codes 1..31 give N x 1.024 ms, 32..63 give 32 x 1.024 ms x (N-31)
// - wait slot index comes from step assignment bits 3:0
// - clock enable slot index comes from step assignment bits 7:4
// - each slot lasts its coded length, the wait adds on top
`timescale 1ns/100ps
module sqt_top
#(
  parameter int HOLD_LIMIT_TICKS = sqt_pkg::HOLD_LIMIT_TICKS,
  parameter int SETTLE_STEP_TICKS = sqt_pkg::SETTLE_STEP_TICKS
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic seq_slot_start_in,
  input wire logic [3:0] seq_slot_in,
  input wire logic seq_dir_up_in,
  input wire logic [3:0] slot_length_code_in,
  output logic slot_done_out,
  output logic hold_active_out,
  output logic hold_timeout_out,
  input wire logic hold_release_pin_in,
  input wire logic osc_clk_in,
  input wire logic backup_xtal_present_in,
  input wire logic slow_clk_pin_function_in,
  input wire logic slow_clk_out_delay_in,
  output logic slow_clk_pin_out,
  output logic rtc_clk_en_out,
  input wire logic external_wake_event_in,
  input wire logic system_domain_up_in,
  input wire logic power_domain_up_in,
  input wire logic reset_mode_exit_in,
  output logic host_rst_n_out
);

  localparam int TW = sqt_pkg::TMR_W;
  localparam int TI_SLOT = 0;
  localparam int TI_HOLD = 1;
  localparam int TI_SETTLE = 2;
  localparam int TI_RST = 3;
  localparam int N_TMR = 4;

  logic [7:0] step_assign_q;
  logic [7:0] seq_hold_control_q;
  logic [7:0] slow_clock_gating_q;
  logic [7:0] host_reset_timing_q;
  logic [7:0] rdata_q;
  logic xtal_load_q;

  logic pin_s1_q;
  logic pin_s2_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic xt_s1_q;
  logic xt_s2_q;
  logic [9:0] tick_cnt_q;
  logic tick_q;

  sqt_pkg::sqt_state_t state_q;
  logic slot_done_q;
  logic hold_active_q;
  logic hold_timeout_q;
  logic hold_here;
  logic hold_load;
  logic [TW-1:0] hold_len;

  logic en_slot_q;
  logic xtal_prev_q;
  logic [1:0] osc_edges_q;
  logic settle_started_q;
  logic settle_done_q;
  logic settle_go;
  logic settled;
  logic slow_pin_q;
  logic rtc_en_q;

  logic rst_n_q;
  logic trig_hit;
  logic [TW-1:0] rst_len;

  sqt_tmr_if tif[N_TMR] ();

  // ==========================================================
  // timer instances
  genvar gi;
  generate
    for (gi = 0; gi < N_TMR; gi++)
    begin : g_tmr
      sqt_timer u_tmr
      (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .t(tif[gi])
      );
      assign tif[gi].tick = tick_q;
    end
  endgenerate

  // ==========================================================
  // tick prescaler
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || tick_cnt_q == 10'(sqt_pkg::TICK_CYC - 1))
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == 10'(sqt_pkg::TICK_CYC - 1));
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk_in)
  begin
    xt_s1_q <= backup_xtal_present_in;
    xt_s2_q <= xt_s1_q;
    if (rst_in)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= hold_release_pin_in;
      pin_s2_q <= pin_s1_q;
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // ==========================================================
  // register file
  // strap synchroniser runs through reset, so it is settled when the
  // crystal bit is taken two edges after reset release
  logic xtal_load2_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      step_assign_q <= sqt_pkg::REG_RESET;
      seq_hold_control_q <= sqt_pkg::REG_RESET;
      slow_clock_gating_q <= sqt_pkg::REG_RESET;
      host_reset_timing_q <= sqt_pkg::REG_RESET;
      xtal_load_q <= 1'b1;
      xtal_load2_q <= 1'b1;
    end
    else
    begin
      xtal_load_q <= xtal_load2_q;
      xtal_load2_q <= 1'b0;
      if (reg_wr_in)
      begin
        case (reg_addr_in)
          sqt_pkg::ADDR_STEP_ASSIGN: step_assign_q <= reg_wdata_in;
          sqt_pkg::ADDR_SEQ_HOLD: seq_hold_control_q <= reg_wdata_in;
          sqt_pkg::ADDR_SLOW_CLK: slow_clock_gating_q <= reg_wdata_in;
          sqt_pkg::ADDR_HOST_RST: host_reset_timing_q <= reg_wdata_in;
          default: ;
        endcase
      end
      if (xtal_load_q && !xtal_load2_q)
      begin
        slow_clock_gating_q[sqt_pkg::XTAL_BIT] <= xt_s2_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        sqt_pkg::ADDR_STEP_ASSIGN: rdata_q <= step_assign_q;
        sqt_pkg::ADDR_SEQ_HOLD: rdata_q <= seq_hold_control_q;
        sqt_pkg::ADDR_SLOW_CLK: rdata_q <= slow_clock_gating_q;
        sqt_pkg::ADDR_HOST_RST: rdata_q <= host_reset_timing_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // wait slot
  wire [1:0] hold_dir =
    seq_hold_control_q[sqt_pkg::HOLD_DIR_HI:sqt_pkg::HOLD_DIR_LO];
  wire [3:0] hold_code =
    seq_hold_control_q[sqt_pkg::HOLD_CODE_HI:sqt_pkg::HOLD_CODE_LO];
  wire hold_src = seq_hold_control_q[sqt_pkg::HOLD_SRC_BIT];
  wire hold_limit = seq_hold_control_q[sqt_pkg::HOLD_LIMIT_BIT];
  wire [3:0] wait_slot =
    step_assign_q[sqt_pkg::WAIT_SLOT_HI:sqt_pkg::WAIT_SLOT_LO];
  wire [3:0] en_slot =
    step_assign_q[sqt_pkg::EN_SLOT_HI:sqt_pkg::EN_SLOT_LO];
  logic [3:0] cur_slot_q;
  logic cur_up_q;

  always_comb
  begin
    hold_here = (cur_slot_q == wait_slot) &&
      (cur_up_q ? hold_dir[0] : hold_dir[1]);
    // code n stretches 512 us by 2^(n-1); 8.39 s at the top is within 10 %
    hold_len = TW'(sqt_pkg::HOLD_BASE_TICKS) << (hold_code - 4'h1);
    hold_load = 1'b0;
    if (state_q == sqt_pkg::ST_SLOT && tif[TI_SLOT].done && hold_here)
    begin
      hold_load = hold_src ? (hold_code != 4'h0) : hold_limit;
    end
    if (!hold_src)
    begin
      hold_len = TW'(HOLD_LIMIT_TICKS);
    end
  end

  assign tif[TI_SLOT].load = seq_slot_start_in;
  assign tif[TI_SLOT].len = TW'(sqt_pkg::SLOT_TICKS[slot_length_code_in]);
  assign tif[TI_HOLD].load = hold_load;
  assign tif[TI_HOLD].len = hold_len;

  // a new slot start always restarts the slot, aborting any hold
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= sqt_pkg::ST_IDLE;
      cur_slot_q <= 4'h0;
      cur_up_q <= 1'b0;
      slot_done_q <= 1'b0;
      hold_active_q <= 1'b0;
      hold_timeout_q <= 1'b0;
    end
    else
    begin
      slot_done_q <= 1'b0;
      hold_timeout_q <= 1'b0;
      case (state_q)
        sqt_pkg::ST_IDLE, sqt_pkg::ST_LEAVE:
        begin
          state_q <= sqt_pkg::ST_IDLE;
        end
        sqt_pkg::ST_SLOT:
        begin
          if (tif[TI_SLOT].done)
          begin
            if (hold_here && !(hold_src && hold_code == 4'h0))
            begin
              state_q <= sqt_pkg::ST_HOLD;
              hold_active_q <= 1'b1;
            end
            else
            begin
              state_q <= sqt_pkg::ST_LEAVE;
              slot_done_q <= 1'b1;
            end
          end
        end
        sqt_pkg::ST_HOLD:
        begin
          if (hold_src ? tif[TI_HOLD].done : pin_s2_q)
          begin
            state_q <= sqt_pkg::ST_LEAVE;
            slot_done_q <= 1'b1;
            hold_active_q <= 1'b0;
          end
          else if (!hold_src && hold_limit && tif[TI_HOLD].done)
          begin
            state_q <= sqt_pkg::ST_LEAVE;
            slot_done_q <= 1'b1;
            hold_active_q <= 1'b0;
            hold_timeout_q <= 1'b1;
          end
        end
        default:
        begin
          state_q <= sqt_pkg::ST_IDLE;
        end
      endcase
      if (seq_slot_start_in)
      begin
        state_q <= sqt_pkg::ST_SLOT;
        cur_slot_q <= seq_slot_in;
        cur_up_q <= seq_dir_up_in;
        hold_active_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // slow clock enable slot and crystal settle
  wire [2:0] settle_code =
    slow_clock_gating_q[sqt_pkg::SETTLE_CODE_HI:sqt_pkg::SETTLE_CODE_LO];
  wire xtal = slow_clock_gating_q[sqt_pkg::XTAL_BIT];
  wire osc_fall = osc_s3_q && !osc_s2_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      en_slot_q <= 1'b0;
    end
    else if (seq_slot_start_in && seq_slot_in == en_slot)
    begin
      en_slot_q <= seq_dir_up_in;
    end
  end

  always_comb
  begin
    if (slow_clock_gating_q[sqt_pkg::SETTLE_SRC_BIT])
    begin
      settle_go = xtal && !xtal_prev_q;
    end
    else
    begin
      settle_go = xtal && osc_fall &&
        osc_edges_q == 2'(sqt_pkg::OSC_START_EDGES - 1);
    end
  end

  assign tif[TI_SETTLE].load = settle_go && !settle_started_q;
  assign tif[TI_SETTLE].len =
    TW'(settle_code) * TW'(SETTLE_STEP_TICKS);
  assign settled = settle_done_q || settle_code == 3'h0;

  // losing the crystal re-arms the start detector
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      xtal_prev_q <= 1'b0;
      osc_edges_q <= 2'h0;
      settle_started_q <= 1'b0;
      settle_done_q <= 1'b0;
    end
    else
    begin
      xtal_prev_q <= xtal;
      if (!xtal)
      begin
        osc_edges_q <= 2'h0;
        settle_started_q <= 1'b0;
        settle_done_q <= 1'b0;
      end
      else
      begin
        if (osc_fall && osc_edges_q != 2'(sqt_pkg::OSC_START_EDGES))
        begin
          osc_edges_q <= osc_edges_q + 2'h1;
        end
        if (settle_go)
        begin
          settle_started_q <= 1'b1;
        end
        if (tif[TI_SETTLE].done)
        begin
          settle_done_q <= 1'b1;
        end
      end
    end
  end

  wire rtc_ok = !slow_clock_gating_q[sqt_pkg::RTC_GATE_BIT] || settled;
  wire pin_ok = !slow_clock_gating_q[sqt_pkg::PIN_GATE_BIT] || settled;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rtc_en_q <= 1'b0;
      slow_pin_q <= 1'b0;
    end
    else
    begin
      rtc_en_q <= en_slot_q && rtc_ok;
      slow_pin_q <= osc_s2_q && en_slot_q && pin_ok &&
        slow_clock_gating_q[sqt_pkg::CLK_OUT_EN_BIT] &&
        slow_clk_pin_function_in && !slow_clk_out_delay_in;
    end
  end

  // ==========================================================
  // host reset release
  wire [1:0] trig_sel =
    host_reset_timing_q[sqt_pkg::RST_TRIG_HI:sqt_pkg::RST_TRIG_LO];
  wire [5:0] rst_code =
    host_reset_timing_q[sqt_pkg::RST_CODE_HI:sqt_pkg::RST_CODE_LO];

  always_comb
  begin
    case (trig_sel)
      sqt_pkg::TRIG_WAKE: trig_hit = external_wake_event_in;
      sqt_pkg::TRIG_SYSTEM_DOMAIN_UP: trig_hit = system_domain_up_in;
      sqt_pkg::TRIG_POWER_DOMAIN_UP: trig_hit = power_domain_up_in;
      sqt_pkg::TRIG_RST_EXIT: trig_hit = reset_mode_exit_in;
      default: trig_hit = 1'b0;
    endcase
    if (rst_code <= 6'(sqt_pkg::RST_SHORT_MAX))
    begin
      rst_len = TW'(rst_code) * TW'(sqt_pkg::RST_UNIT_TICKS);
    end
    else
    begin
      rst_len = TW'(rst_code - 6'(sqt_pkg::RST_SHORT_MAX)) *
        TW'(sqt_pkg::RST_LONG_MULT * sqt_pkg::RST_UNIT_TICKS);
    end
  end

  assign tif[TI_RST].load = trig_hit;
  assign tif[TI_RST].len = rst_len;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rst_n_q <= 1'b0;
    end
    else if (trig_hit)
    begin
      rst_n_q <= 1'b0;
    end
    else if (tif[TI_RST].done)
    begin
      rst_n_q <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_out = rdata_q;
  assign slot_done_out = slot_done_q;
  assign hold_active_out = hold_active_q;
  assign hold_timeout_out = hold_timeout_q;
  assign slow_clk_pin_out = slow_pin_q;
  assign rtc_clk_en_out = rtc_en_q;
  assign host_rst_n_out = rst_n_q;

endmodule : sqt_top

// ---- verilog/sqt_pkg.sv ----
// constants, register map and field layout of the sequencer wait/clock/reset timers
package sqt_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_MHZ = 25;
  localparam int TICK_NS = 32000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int HOLD_LIMIT_MS = 500;
  localparam int HOLD_LIMIT_TICKS = HOLD_LIMIT_MS * 1000 / TICK_US;
  localparam int HOLD_BASE_US = 512;
  localparam int HOLD_BASE_TICKS = HOLD_BASE_US / TICK_US;
  localparam int SETTLE_STEP_MS = 520;
  localparam int SETTLE_STEP_TICKS = SETTLE_STEP_MS * 1000 / TICK_US;
  localparam int RST_UNIT_NS = 1024000;
  localparam int RST_UNIT_TICKS = RST_UNIT_NS / TICK_NS;
  localparam int RST_LONG_MULT = 32;
  localparam int RST_SHORT_MAX = 31;
  localparam int OSC_START_EDGES = 3;
  localparam int TMR_W = 24;

  // slot lengths in ticks, index is the slot length code
  localparam logic [8:0] SLOT_TICKS [16] = '{
    9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h008,
    9'h009, 9'h00c, 9'h00e, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100
  };

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_STEP_ASSIGN = 8'h92;
  localparam logic [7:0] ADDR_SEQ_HOLD = 8'h97;
  localparam logic [7:0] ADDR_SLOW_CLK = 8'h98;
  localparam logic [7:0] ADDR_HOST_RST = 8'h99;
  localparam logic [7:0] REG_RESET = 8'h00;

  // step assignment fields
  localparam int EN_SLOT_HI = 7;
  localparam int EN_SLOT_LO = 4;
  localparam int WAIT_SLOT_HI = 3;
  localparam int WAIT_SLOT_LO = 0;
  // hold control fields
  localparam int HOLD_DIR_HI = 7;
  localparam int HOLD_DIR_LO = 6;
  localparam int HOLD_LIMIT_BIT = 5;
  localparam int HOLD_SRC_BIT = 4;
  localparam int HOLD_CODE_HI = 3;
  localparam int HOLD_CODE_LO = 0;
  // slow clock gating fields
  localparam int CLK_OUT_EN_BIT = 7;
  localparam int RTC_GATE_BIT = 6;
  localparam int PIN_GATE_BIT = 5;
  localparam int SETTLE_SRC_BIT = 4;
  localparam int XTAL_BIT = 3;
  localparam int SETTLE_CODE_HI = 2;
  localparam int SETTLE_CODE_LO = 0;
  // host reset timing fields
  localparam int RST_TRIG_HI = 7;
  localparam int RST_TRIG_LO = 6;
  localparam int RST_CODE_HI = 5;
  localparam int RST_CODE_LO = 0;

  typedef enum logic [1:0]
  {
    TRIG_WAKE = 2'h0,
    TRIG_SYSTEM_DOMAIN_UP = 2'h1,
    TRIG_POWER_DOMAIN_UP = 2'h2,
    TRIG_RST_EXIT = 2'h3
  } sqt_trig_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_SLOT = 2'h1,
    ST_HOLD = 2'h3,
    ST_LEAVE = 2'h2
  } sqt_state_t;

endpackage : sqt_pkg

// ---- verilog/sqt_tmr_if.sv ----
// control and status signals of one tick-driven down counter
`timescale 1ns/100ps
interface sqt_tmr_if;
  logic load;
  logic [sqt_pkg::TMR_W-1:0] len;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output load, output len, output tick, input busy, input done);
  modport tmr (input load, input len, input tick, output busy, output done);
endinterface : sqt_tmr_if

// ---- verilog/sqt_timer.sv ----
// tick-driven down counter with a one-cycle done pulse
`timescale 1ns/100ps
module sqt_timer
(
  input wire logic clk_in,
  input wire logic rst_in,
  sqt_tmr_if.tmr t
);

  logic [sqt_pkg::TMR_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  // ==========================================================
  // counter
  // a zero length finishes on the next edge without waiting a tick
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (t.load)
    begin
      cnt_q <= t.len;
      busy_q <= (t.len != '0);
      done_q <= (t.len == '0);
    end
    else if (busy_q && t.tick)
    begin
      cnt_q <= cnt_q - 1'b1;
      busy_q <= (cnt_q != {{(sqt_pkg::TMR_W-1){1'b0}}, 1'b1});
      done_q <= (cnt_q == {{(sqt_pkg::TMR_W-1){1'b0}}, 1'b1});
    end
    else
    begin
      done_q <= 1'b0;
    end
  end

  assign t.busy = busy_q;
  assign t.done = done_q;

endmodule : sqt_timer

// ---- verification/sqt_host_model.sv ----
// host side model: answers the wait slot on the hold release pin
`timescale 1ns/100ps
module sqt_host_model
(
  input wire logic clk_in,
  input wire logic hold_active_in,
  input wire logic [7:0] delay_in,
  output logic hold_release_pin_out = 1'b0
);
  // ==========================================================
  // release after delay_in cycles; 8'hff never answers
  logic [7:0] wait_q = 8'h00;

  always @(posedge clk_in)
  begin
    if (!hold_active_in)
      wait_q <= 8'h00;
    else if (wait_q != 8'hff)
      wait_q <= wait_q + 8'h01;
    // pin drops once the hold is over, so a new slot starts from idle
    hold_release_pin_out <= hold_active_in && delay_in != 8'hff &&
      wait_q >= delay_in;
  end
endmodule : sqt_host_model

// ---- verification/sqt_top_asserts.sv ----
// port-level assertions for the sequencer wait, clock and reset timers
`timescale 1ns/100ps
module sqt_top_asserts
#(
  parameter int HOLD_LIMIT_TICKS = 20,
  parameter int SETTLE_STEP_TICKS = 10
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic seq_slot_start_in,
  input wire logic [3:0] seq_slot_in,
  input wire logic seq_dir_up_in,
  input wire logic [3:0] slot_length_code_in,
  input wire logic slot_done_out,
  input wire logic hold_active_out,
  input wire logic hold_timeout_out,
  input wire logic hold_release_pin_in,
  input wire logic osc_clk_in,
  input wire logic backup_xtal_present_in,
  input wire logic slow_clk_pin_function_in,
  input wire logic slow_clk_out_delay_in,
  input wire logic slow_clk_pin_out,
  input wire logic rtc_clk_en_out,
  input wire logic external_wake_event_in,
  input wire logic system_domain_up_in,
  input wire logic power_domain_up_in,
  input wire logic reset_mode_exit_in,
  input wire logic host_rst_n_out
);
  // ==========================================================
  // register shadows
  logic [7:0] hold_q;
  logic [7:0] clk_q;
  logic [7:0] rst_q;
  // crystal bit is loaded from the strap, so trust clk_q only once written
  logic clk_ok_q;
  logic [3:0] trig_v;
  logic trig_hit;

  always_ff @(posedge ref_clk_in)
    if (rst_in) hold_q <= 8'h00;
    else if (reg_wr_in && reg_addr_in == sqt_pkg::ADDR_SEQ_HOLD)
      hold_q <= reg_wdata_in;

  always_ff @(posedge ref_clk_in)
    if (rst_in) rst_q <= 8'h00;
    else if (reg_wr_in && reg_addr_in == sqt_pkg::ADDR_HOST_RST)
      rst_q <= reg_wdata_in;

  always_ff @(posedge ref_clk_in)
    if (rst_in)
    begin
      clk_q <= 8'h00;
      clk_ok_q <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == sqt_pkg::ADDR_SLOW_CLK)
    begin
      clk_q <= reg_wdata_in;
      clk_ok_q <= 1'b1;
    end

  assign trig_v = {reset_mode_exit_in, power_domain_up_in,
    system_domain_up_in, external_wake_event_in};
  assign trig_hit = trig_v[rst_q[7:6]];

  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_done_one_cycle: assert property (slot_done_out |=> !slot_done_out)
    else $error("slot done longer than one cycle");
  a_timeout_done: assert property (hold_timeout_out |-> slot_done_out)
    else $error("hold timeout without slot done");
  a_timeout_src: assert property (hold_timeout_out |->
    $past(!hold_q[4] && hold_q[5] && hold_active_out))
    else $error("hold timeout outside a limited pin wait");
  a_pin_release: assert property (
    (hold_active_out && !hold_q[4] && hold_release_pin_in)[*3]
    |=> !hold_active_out)
    else $error("pin wait not ended by release pin");
  a_no_hold_dir: assert property (
    !hold_active_out && hold_q[7:6] == 2'b00 |=> !hold_active_out)
    else $error("hold entered with direction field 00");
  a_code0_no_hold: assert property (
    !hold_active_out && hold_q[4] && hold_q[3:0] == 4'h0
    |=> !hold_active_out)
    else $error("hold entered with timer code 0");
  a_rst_on_trig: assert property (trig_hit |=> !host_rst_n_out)
    else $error("host reset not asserted after trigger");
  a_rst_zero_code: assert property (
    trig_hit && rst_q[5:0] == 6'h00 ##1 !trig_hit |-> ##1 host_rst_n_out)
    else $error("host reset not released for code 0");
  a_rst_only_trig: assert property (
    host_rst_n_out && !trig_hit |=> host_rst_n_out)
    else $error("host reset asserted without selected trigger");
  a_pin_clk_cause: assert property (slow_clk_pin_out |->
    $past(clk_q[7] && slow_clk_pin_function_in && !slow_clk_out_delay_in))
    else $error("pin clock driven while not enabled");
  a_rtc_gate: assert property (
    (clk_ok_q && clk_q[6] && !clk_q[3] && clk_q[2:0] != 3'h0)[*2]
    |=> !rtc_clk_en_out)
    else $error("rtc clock enabled before settling");
  a_pin_gate: assert property (
    (clk_ok_q && clk_q[5] && !clk_q[3] && clk_q[2:0] != 3'h0)[*2]
    |=> !slow_clk_pin_out)
    else $error("pin clock driven before settling");

  c_timeout: cover property (hold_timeout_out);
  c_release: cover property ($fell(hold_active_out) && slot_done_out);
  c_rtc_on: cover property ($rose(rtc_clk_en_out));
endmodule : sqt_top_asserts

bind sqt_top sqt_top_asserts #(
  .HOLD_LIMIT_TICKS(HOLD_LIMIT_TICKS),
  .SETTLE_STEP_TICKS(SETTLE_STEP_TICKS)
) u_sqt_asserts (.*);

// ---- verification/tb_sqt_top.sv ----
// self-checking bench for the sequencer wait, clock and reset timers
`timescale 1ns/100ps
module tb_sqt_top;
  localparam int TICK = sqt_pkg::TICK_CYC;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic seq_slot_start_in = 1'b0, seq_dir_up_in = 1'b0;
  logic [3:0] seq_slot_in = 4'h0, slot_length_code_in = 4'h0;
  logic slot_done_out, hold_active_out, hold_timeout_out, hold_release_pin_in;
  logic osc_clk_in = 1'b0, backup_xtal_present_in = 1'b1;
  logic slow_clk_pin_function_in = 1'b1, slow_clk_out_delay_in = 1'b0;
  logic slow_clk_pin_out, rtc_clk_en_out, host_rst_n_out;
  logic [3:0] trig_v = 4'h0;
  logic [7:0] rel_delay = 8'h10;
  logic hold_seen, to_seen, clk_seen;
  int fails = 0, total_checks = 0, cyc = 0, n;
  wire external_wake_event_in = trig_v[0];
  wire system_domain_up_in = trig_v[1];
  wire power_domain_up_in = trig_v[2];
  wire reset_mode_exit_in = trig_v[3];

  always #20 ref_clk_in = ~ref_clk_in;
  // oscillator sped up so gating shows within a short run
  always #410 osc_clk_in = ~osc_clk_in;

  sqt_top #(.HOLD_LIMIT_TICKS(20), .SETTLE_STEP_TICKS(10)) dut (.*);
  sqt_host_model host (.clk_in(ref_clk_in), .hold_active_in(hold_active_out),
    .delay_in(rel_delay), .hold_release_pin_out(hold_release_pin_in));

  // ==========================================================
  // tasks
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    check(reg_rdata_out, e);
  endtask : rd

  task automatic slot(input logic [3:0] s, input logic up, input logic [3:0] c);
    @(negedge ref_clk_in);
    seq_slot_in = s;
    seq_dir_up_in = up;
    slot_length_code_in = c;
    seq_slot_start_in = 1'b1;
    hold_seen = 1'b0;
    n = 0;
    @(negedge ref_clk_in);
    seq_slot_start_in = 1'b0;
    while (slot_done_out !== 1'b1 && n < 40000)
    begin
      hold_seen |= hold_active_out;
      @(negedge ref_clk_in);
      n++;
    end
    to_seen = hold_timeout_out;
  endtask : slot

  task automatic pulse(input int k);
    @(negedge ref_clk_in);
    trig_v = 4'h1 << k;
    @(negedge ref_clk_in);
    trig_v = 4'h0;
  endtask : pulse

  task automatic watch(input int k);
    clk_seen = 1'b0;
    repeat (k) @(negedge ref_clk_in) clk_seen |= slow_clk_pin_out;
  endtask : watch

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 98000)
    begin
      fails++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check(host_rst_n_out, 1'b0);
    rd(sqt_pkg::ADDR_SLOW_CLK, 8'h08);
    rd(sqt_pkg::ADDR_HOST_RST, sqt_pkg::REG_RESET);
    wr(8'h9a, 8'h5a);
    rd(8'h9a, 8'h00);
    wr(sqt_pkg::ADDR_STEP_ASSIGN, 8'h35);
    rd(sqt_pkg::ADDR_STEP_ASSIGN, 8'h35);
    wr(sqt_pkg::ADDR_SEQ_HOLD, 8'h51);
    rd(sqt_pkg::ADDR_SEQ_HOLD, 8'h51);
    // one-tick slot plus a 16-tick hold timer
    slot(4'h5, 1'b1, 4'h0);
    check(hold_seen, 1'b1);
    check(n >= 16 * TICK && n <= 17 * TICK + 8, 1'b1);
    slot(4'h4, 1'b1, 4'h4);
    check({hold_seen, n >= 4 * TICK && n <= 5 * TICK + 8}, 2'b01);
    for (int d = 0; d < 4; d++)
      for (int u = 0; u < 2; u++)
      begin
        wr(sqt_pkg::ADDR_SEQ_HOLD, {d[1:0], 6'h00});
        slot(4'h5, u[0], 4'h0);
        check(hold_seen, u ? d[0] : d[1]);
      end
    rel_delay = 8'hc8;
    slot(4'h5, 1'b0, 4'h0);
    check(n >= 200 && n <= TICK + 230, 1'b1);
    wr(sqt_pkg::ADDR_SEQ_HOLD, 8'hd0);
    slot(4'h5, 1'b1, 4'h0);
    check(hold_seen, 1'b0);
    rel_delay = 8'hff;
    wr(sqt_pkg::ADDR_SEQ_HOLD, 8'h60);
    slot(4'h5, 1'b1, 4'h0);
    check({to_seen, n >= 20 * TICK && n <= 22 * TICK}, 2'b11);
    for (int t = 0; t < 4; t++)
    begin
      wr(sqt_pkg::ADDR_HOST_RST, {t[1:0], 6'h00});
      pulse((t + 1) % 4);
      repeat (3) @(negedge ref_clk_in);
      check(host_rst_n_out, t != 0);
      pulse(t);
      repeat (2) @(negedge ref_clk_in);
      check(host_rst_n_out, 1'b1);
    end
    wr(sqt_pkg::ADDR_HOST_RST, 8'h01);
    rd(sqt_pkg::ADDR_HOST_RST, 8'h01);
    pulse(0);
    @(negedge ref_clk_in);
    n = 0;
    while (host_rst_n_out !== 1'b1 && n < 40000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check(n >= 31 * TICK && n <= 33 * TICK, 1'b1);
    slot(4'h3, 1'b1, 4'h0);
    // settle of 10 ticks, started by osc edges then by crystal bit rise
    for (int m = 0; m < 2; m++)
    begin
      wr(sqt_pkg::ADDR_SLOW_CLK, m ? 8'hf1 : 8'he1);
      wr(sqt_pkg::ADDR_SLOW_CLK, m ? 8'hf9 : 8'he9);
      watch(4 * TICK);
      check({rtc_clk_en_out, clk_seen}, 2'b00);
      watch(8 * TICK);
      check({rtc_clk_en_out, clk_seen}, 2'b11);
    end
    slow_clk_out_delay_in = 1'b1;
    watch(2 * TICK);
    check(clk_seen, 1'b0);
    slow_clk_out_delay_in = 1'b0;
    slot(4'h3, 1'b0, 4'h0);
    repeat (4) @(negedge ref_clk_in);
    watch(60);
    check({rtc_clk_en_out, clk_seen}, 2'b00);
    conclude();
  end
endmodule : tb_sqt_top
